/* File: rtl/smlc_pkg.sv */
package smlc_pkg;

  // ----------------------------------------------------------------
  // clocking and timebase
  // ----------------------------------------------------------------
  localparam int unsigned SMLC_CLK_HZ         = 100000000;
  localparam int unsigned SMLC_TIMEBASE_MS    = 20;
  localparam int unsigned SMLC_TIMEBASE_CYC   = (SMLC_CLK_HZ / 1000) * SMLC_TIMEBASE_MS;

  // ----------------------------------------------------------------
  // register map (byte offsets, one word every 4 bytes)
  // ----------------------------------------------------------------
  localparam int unsigned SMLC_ADDR_W         = 8;
  localparam int unsigned SMLC_DATA_W         = 32;
  localparam logic [7:0]  SMLC_BASE_DEFAULT   = 8'h00;
  localparam logic [7:0]  SMLC_OFS_STATUS     = 8'h00;
  localparam logic [7:0]  SMLC_OFS_SET        = 8'h04;

  // status field positions
  localparam int unsigned SMLC_BIT_DTR        = 0;
  localparam int unsigned SMLC_BIT_DSR        = 1;
  localparam int unsigned SMLC_BIT_RTS        = 2;
  localparam int unsigned SMLC_BIT_CTS        = 3;
  localparam int unsigned SMLC_BIT_DCD        = 4;
  localparam int unsigned SMLC_BIT_RI         = 5;
  // set register field positions
  localparam int unsigned SMLC_SET_RTS        = 0;
  localparam int unsigned SMLC_SET_DTR        = 1;

  localparam logic [31:0] SMLC_RD_ZERO        = 32'h0000_0000;

  // ----------------------------------------------------------------
  // modem line bundles
  // ----------------------------------------------------------------
  typedef struct packed {
    logic ring;
    logic carrier;
    logic clear_to_send;
    logic set_ready;
  } smlc_lines_in_s;

  typedef struct packed {
    logic terminal_ready;
    logic request_to_send;
  } smlc_lines_out_s;

endpackage : smlc_pkg

/* File: rtl/smlc_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module smlc_sync
  import smlc_pkg::*;
#(
  parameter int unsigned WIDTH = 4
) (
  input  wire logic             core_clk_in, // module clock
  input  wire logic             rst_n_in,    // sync reset, active low
  input  wire logic [WIDTH-1:0] async_in,    // raw inputs
  output var  logic [WIDTH-1:0] sync_out     // synchronised inputs
);

  logic [WIDTH-1:0] stage1;

  // ----------------------------------------------------------------
  // two-flop synchroniser per bit
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
          stage1[g]   <= 1'b0;
          sync_out[g] <= 1'b0;
        end else begin
          stage1[g]   <= async_in[g];
          sync_out[g] <= stage1[g];
        end
      end
    end
  endgenerate

endmodule : smlc_sync
`default_nettype wire

/* File: rtl/smlc_line_ctrl.sv */
// What this block does
// RULE_01 - status snapshot of all six lines refreshed once every 20 ms timebase tick
// RULE_02 - output pins follow the set register at once, no timebase wait
// RULE_03 - each status read returns the current snapshot of all six lines
// RULE_04 - snapshot holds readback of driven DTR and RTS plus four partner inputs
// RULE_05 - partner raises CTS in answer to RTS; device only reports it
// RULE_06 - a set write drives RTS and DTR from the two supplied bits
// RULE_07 - reads and sets never raise an error; no error flag exists
// RULE_08 - partner holds a level longer than poll plus update plus response time
// RULE_09 - host addresses each access at this module's base address
// RULE_10 - partner inputs pass two flip-flops before entering the snapshot
`timescale 1ns/1ps
`default_nettype none
module smlc_line_ctrl
  import smlc_pkg::*;
#(
  parameter int unsigned            TIMEBASE_CYC = SMLC_TIMEBASE_CYC,
  parameter logic [SMLC_ADDR_W-1:0] BASE_ADDR    = SMLC_BASE_DEFAULT
) (
  input  wire logic                   core_clk_in,             // module clock, 100 MHz
  input  wire logic                   rst_n_in,                // sync reset, active low
  input  wire logic [SMLC_ADDR_W-1:0] reg_addr_in,             // register byte address
  input  wire logic [SMLC_DATA_W-1:0] reg_wdata_in,            // write data
  input  wire logic                   reg_wr_in,               // write strobe
  input  wire logic                   reg_rd_in,               // read strobe
  output var  logic [SMLC_DATA_W-1:0] reg_rdata_out,           // read data, cycle after strobe
  input  wire logic                   set_ready_in,            // partner set-ready pin
  input  wire logic                   clear_to_send_in,        // partner clear-to-send pin
  input  wire logic                   carrier_detect_input_in, // partner carrier-detect pin
  input  wire logic                   ring_indicator_input_in, // partner ring pin
  output var  logic                   request_to_send_out,     // request-to-send pin
  output var  logic                   terminal_ready_out       // terminal-ready pin
);

  localparam int unsigned TB_W = $clog2(TIMEBASE_CYC);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic addr_hit(input logic [SMLC_ADDR_W-1:0] a,
                                    input logic [SMLC_ADDR_W-1:0] ofs);
    addr_hit = (a == (BASE_ADDR + ofs));
  endfunction : addr_hit

  logic            line_output_set;
  logic            line_status_read;
  smlc_lines_in_s  raw_in;
  smlc_lines_in_s  sync_in;
  smlc_lines_out_s drive;
  smlc_lines_out_s next_drive;
  logic [5:0]      snapshot;
  logic [TB_W-1:0] tb_cnt;
  logic            tb_tick;

  assign line_output_set  = reg_wr_in && addr_hit(reg_addr_in, SMLC_OFS_SET);    // RULE_09
  assign line_status_read = reg_rd_in && addr_hit(reg_addr_in, SMLC_OFS_STATUS); // RULE_09

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  assign raw_in = '{ring:          ring_indicator_input_in,
                    carrier:       carrier_detect_input_in,
                    clear_to_send: clear_to_send_in,
                    set_ready:     set_ready_in};

  smlc_sync #(
    .WIDTH ($bits(smlc_lines_in_s))
  ) u_sync (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .async_in    (raw_in),    // RULE_10
    .sync_out    (sync_in)
  );

  // ----------------------------------------------------------------
  // output line control
  // ----------------------------------------------------------------
  always_comb begin
    next_drive = drive;
    if (line_output_set) begin
      next_drive.request_to_send = reg_wdata_in[SMLC_SET_RTS]; // RULE_06
      next_drive.terminal_ready  = reg_wdata_in[SMLC_SET_DTR]; // RULE_06
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      drive <= '0;
    end else begin
      drive <= next_drive;
    end
  end

  // pins straight from the control flops, independent of timebase
  assign request_to_send_out = drive.request_to_send; // RULE_02
  assign terminal_ready_out  = drive.terminal_ready;  // RULE_02

  // ----------------------------------------------------------------
  // 20 ms timebase
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      tb_cnt  <= '0;
      tb_tick <= 1'b0;
    end else if (tb_cnt == TB_W'(TIMEBASE_CYC - 1)) begin
      tb_cnt  <= '0;
      tb_tick <= 1'b1;
    end else begin
      tb_cnt  <= tb_cnt + 1'b1;
      tb_tick <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // status snapshot
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      snapshot <= '0;
    end else if (tb_tick) begin // RULE_01
      snapshot[SMLC_BIT_DTR] <= drive.terminal_ready;   // RULE_04
      snapshot[SMLC_BIT_DSR] <= sync_in.set_ready;      // RULE_04
      snapshot[SMLC_BIT_RTS] <= drive.request_to_send;  // RULE_04
      snapshot[SMLC_BIT_CTS] <= sync_in.clear_to_send;  // RULE_05
      snapshot[SMLC_BIT_DCD] <= sync_in.carrier;        // RULE_04
      snapshot[SMLC_BIT_RI]  <= sync_in.ring;           // RULE_04
    end
  end

  // ----------------------------------------------------------------
  // read port, no error path at all
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= SMLC_RD_ZERO;
    end else if (line_status_read) begin
      reg_rdata_out <= {{(SMLC_DATA_W-6){1'b0}}, snapshot}; // RULE_03 RULE_07
    end else if (reg_rd_in && addr_hit(reg_addr_in, SMLC_OFS_SET)) begin
      reg_rdata_out <= {{(SMLC_DATA_W-2){1'b0}}, drive.terminal_ready, drive.request_to_send};
    end else begin
      reg_rdata_out <= SMLC_RD_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_set_drives_pins: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // RULE_06
    line_output_set |=> (request_to_send_out == $past(reg_wdata_in[SMLC_SET_RTS]))
                        && (terminal_ready_out == $past(reg_wdata_in[SMLC_SET_DTR])))
    else $error("set write did not reach pins");

  chk_pins_hold_idle: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // RULE_02
    !line_output_set |=> $stable(request_to_send_out) && $stable(terminal_ready_out))
    else $error("pins changed without set write");

  chk_snap_stable_tick: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // RULE_01
    !tb_tick |=> $stable(snapshot))
    else $error("snapshot changed off the timebase");

  chk_tick_period: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // RULE_01
    tb_tick |=> (tb_cnt == TB_W'(1)) && !tb_tick)
    else $error("timebase tick malformed");

  chk_snap_readback: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // RULE_04
    tb_tick |=> (snapshot[SMLC_BIT_RTS] == $past(request_to_send_out))
                && (snapshot[SMLC_BIT_DTR] == $past(terminal_ready_out)))
    else $error("snapshot lost output readback");

  chk_status_read: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // RULE_03
    line_status_read |=> reg_rdata_out == {{(SMLC_DATA_W-6){1'b0}}, $past(snapshot)})
    else $error("status read wrong value");

  chk_set_readback: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // RULE_06
    (reg_rd_in && addr_hit(reg_addr_in, SMLC_OFS_SET))
      |=> reg_rdata_out == {{(SMLC_DATA_W-2){1'b0}}, $past(terminal_ready_out), $past(request_to_send_out)})
    else $error("set register readback wrong");

  chk_cts_sync: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // RULE_10
    sync_in.clear_to_send == $past(clear_to_send_in, 2))
    else $error("clear-to-send not two-stage synchronised");

  chk_carrier_sync: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // RULE_10
    sync_in.carrier == $past(carrier_detect_input_in, 2))
    else $error("carrier not two-stage synchronised");

  chk_ring_sync: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // RULE_10
    sync_in.ring == $past(ring_indicator_input_in, 2))
    else $error("ring not two-stage synchronised");

  chk_snap_inputs: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // RULE_04
    tb_tick |=> (snapshot[SMLC_BIT_DSR] == $past(set_ready_in, 3))
                && (snapshot[SMLC_BIT_DCD] == $past(carrier_detect_input_in, 3))
                && (snapshot[SMLC_BIT_RI] == $past(ring_indicator_input_in, 3)))
    else $error("snapshot lost partner inputs");

  chk_stray_write: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // RULE_09
    (reg_wr_in && !addr_hit(reg_addr_in, SMLC_OFS_SET))
      |=> $stable(request_to_send_out) && $stable(terminal_ready_out))
    else $error("write off the set address moved pins");

  chk_input_sync: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // RULE_10
    sync_in.set_ready == $past(set_ready_in, 2))
    else $error("set-ready not two-stage synchronised");

  chk_cts_sampled: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // RULE_05
    tb_tick |=> snapshot[SMLC_BIT_CTS] == $past(clear_to_send_in, 3))
    else $error("clear-to-send snapshot wrong");

  chk_no_read_noise: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // RULE_07
    !reg_rd_in |=> reg_rdata_out == SMLC_RD_ZERO)
    else $error("read data outside read cycle");

endmodule : smlc_line_ctrl
`default_nettype wire

/* File: verif/smlc_modem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module smlc_modem_model
  import smlc_pkg::*;
(
  input  wire logic           core_clk_in, // module clock
  input  wire logic           rst_n_in,    // sync reset, active low
  input  wire logic           rts_in,      // request-to-send from device
  input  wire logic [3:0]     delay_in,    // answer delay in cycles
  input  wire logic           ready_in,    // partner ready level
  input  wire logic           carrier_in,  // carrier level
  input  wire logic           ring_in,     // ring level
  output var  smlc_lines_in_s lines_out    // lines towards device
);
  logic [3:0] wait_cnt;
  logic       cts_q;
  // ----------------------------------------------------------------
  // clear-to-send answers request-to-send after a delay
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in || !rts_in) begin
      wait_cnt <= 4'h0;
      cts_q    <= 1'b0;
    end else if (wait_cnt >= delay_in) begin
      cts_q <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
  always_comb begin
    lines_out = '{ring: ring_in, carrier: carrier_in, clear_to_send: cts_q, set_ready: ready_in};
  end
endmodule : smlc_modem_model
`default_nettype wire

/* File: verif/serial_modem_line_control_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_modem_line_control_bench
  import smlc_pkg::*;
;
  localparam int unsigned TB   = 16;
  localparam logic [7:0]  BASE = 8'h40;
  logic           clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic           rdy = 1'b0, car = 1'b0, ring = 1'b0, rts, dtr;
  logic [7:0]     addr = 8'h00;
  logic [31:0]    wdata = 32'h0, rdata, got, prev, expv, mask;
  logic [3:0]     dly = 4'h0;
  logic [1:0]     bits;
  smlc_lines_in_s lines;
  int             n_fail = 0, samples_checked = 0;
  always #5 clk = ~clk;
  smlc_line_ctrl #(.TIMEBASE_CYC(TB), .BASE_ADDR(BASE)) DUT (.core_clk_in(clk), .rst_n_in(rst_n),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .set_ready_in(lines.set_ready), .clear_to_send_in(lines.clear_to_send),
    .carrier_detect_input_in(lines.carrier), .ring_indicator_input_in(lines.ring),
    .request_to_send_out(rts), .terminal_ready_out(dtr));
  smlc_modem_model modem (.core_clk_in(clk), .rst_n_in(rst_n), .rts_in(rts), .delay_in(dly),
    .ready_in(rdy), .carrier_in(car), .ring_in(ring), .lines_out(lines));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  function automatic logic [31:0] exp_stat(input logic d, dsr, r, cts, dcd, ri);
    exp_stat = SMLC_RD_ZERO;
    exp_stat[SMLC_BIT_DTR] = d; exp_stat[SMLC_BIT_DSR] = dsr; exp_stat[SMLC_BIT_RTS] = r;
    exp_stat[SMLC_BIT_CTS] = cts; exp_stat[SMLC_BIT_DCD] = dcd; exp_stat[SMLC_BIT_RI] = ri;
  endfunction : exp_stat
  task stop_test;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(69229));
    mask = exp_stat(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    prev = 32'h0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    #1 check({30'h0, dtr, rts}, 32'h0);
    rd_reg(BASE + SMLC_OFS_STATUS, got);
    check(got, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 24; i++) begin
      bits = (i < 4) ? 2'(i) : 2'($urandom);
      wr_reg(BASE + SMLC_OFS_SET, {30'h0, bits});
      #1 check({30'h0, dtr, rts}, {30'h0, bits[SMLC_SET_DTR], bits[SMLC_SET_RTS]});
      rd_reg(BASE + SMLC_OFS_SET, got);
      check(got, {30'h0, bits});
      @(posedge clk);
      rdy <= 1'($urandom); car <= 1'($urandom); ring <= 1'($urandom); dly <= 4'($urandom);
      rd_reg(BASE + SMLC_OFS_STATUS, got);
      check(got & mask, prev & mask);
      repeat (TB + 24) @(posedge clk);
      expv = exp_stat(bits[SMLC_SET_DTR], rdy, bits[SMLC_SET_RTS], bits[SMLC_SET_RTS], car, ring);
      rd_reg(BASE + SMLC_OFS_STATUS, got);
      check(got, expv);
      prev = expv;
    end
    $display("test random lines done");
    wr_reg(BASE + 8'h08, {30'h0, ~bits});
    wr_reg(8'h04, {30'h0, ~bits});
    #1 check({30'h0, dtr, rts}, {30'h0, bits[SMLC_SET_DTR], bits[SMLC_SET_RTS]});
    rd_reg(BASE + 8'h08, got);
    check(got, 32'h0);
    rd_reg(8'h00, got);
    check(got, 32'h0);
    $display("test unmapped done");
    stop_test();
  end
  initial begin
    #(20000 * 10);
    n_fail++;
    stop_test();
  end
endmodule : serial_modem_line_control_bench
`default_nettype wire
